// ### design/aux_pin_regs.svh
// register offsets, field positions, reset values and selector codes for the aux pin bank
// assumes an 8-bit register port with byte addresses from the management bus engine
`ifndef AUX_PIN_REGS_SVH
`define AUX_PIN_REGS_SVH

`define ADDR_RESET 8'h01
`define ADDR_PIN0_SETUP 8'h02
`define ADDR_PIN1_SETUP 8'h03
`define ADDR_PIN2_SETUP 8'h04
`define ADDR_LEVELS_IN 8'h05
`define ADDR_LEVELS_OUT 8'h06
`define ADDR_EMPHASIS 8'h20

`define SETUP_RESET_VAL 8'h05
`define LEVELS_OUT_RESET_VAL 3'h0
`define EMPHASIS_RESET_VAL 3'h0
`define PIN_RESET_VAL 3'h0
`define OE_N_RESET_VAL 3'h7
`define RDATA_RESET_VAL 8'h00
`define EMPH_LEVEL_RESET_VAL 2'h0
`define SOFT_RESET_BIT 0
`define EMPH_OVERRIDE_BIT 2

`define PULL_NONE 2'h0
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2

`define P0_SEL_SOFT 4'h0
`define P0_SEL_LINK_LOSS 4'h1
`define P0_SEL_CLK_LOS 4'h3
`define P0_SEL_CLK_DET 4'h4
`define P1_SEL_POR 4'h0
`define P1_SEL_SOFT 4'h1
`define P1_SEL_PLL_LOCK 4'h2
`define P1_SEL_LANE_BASE 4'h3
`define P1_SEL_LANE_LAST 4'h7
`define P2_SEL_SOFT 4'h0
`define P2_SEL_AON_CLK 4'h1
`define P2_SEL_SER_CLK 4'h2
`define P2_SEL_DIG_CLK 4'h4

`define NUM_PINS 3
`define NUM_LANES 5

`endif

// ### design/aux_pin_pkg.sv
// types for the aux pin bank
// assumes aux_pin_regs.svh supplies the numeric constants
package aux_pin_pkg;

  typedef struct packed {
    logic [3:0] source_select;
    logic [1:0] pull_control;
    logic input_enable;
    logic output_enable;
  } pin_setup_t;

  typedef struct packed {
    logic override_en;
    logic [1:0] level;
  } emphasis_t;

  typedef struct packed {
    logic link_loss;
    logic clk_los;
    logic clk_detect;
    logic pll_lock;
    logic por;
    logic [4:0] lane_los;
    logic aon_clk;
    logic ser_clk;
    logic dig_clk;
  } status_t;

  typedef struct packed {
    logic pull_up_en;
    logic pull_down_en;
    logic in_buf_en;
  } pad_ctrl_t;

  typedef enum logic [1:0] {
    EMPH_NONE = 2'b00,
    EMPH_LOW = 2'b01,
    EMPH_MEDIUM = 2'b10,
    EMPH_HIGH = 2'b11
  } emph_level_t;

endpackage : aux_pin_pkg

// ### design/aux_pin_reg_store.sv
// small register store for the three pin setup bytes
// assumes single-cycle writes from the bank's register port
`timescale 1ns/10ps
`include "aux_pin_regs.svh"
module aux_pin_reg_store (
  input wire logic sys_clk_i,
  input wire logic clear_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_idx_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [1:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  output aux_pin_pkg::pin_setup_t [2:0] setup_o
);

  logic [2:0][7:0] mem_q;
  logic [2:0][7:0] mem_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  always_comb begin
    mem_d = mem_q;
    rd_d = 8'h00;
    if (clear_i) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        mem_d[i] = `SETUP_RESET_VAL;
      end
    end else if (wr_en_i && wr_idx_i < 2'h3) begin
      mem_d[wr_idx_i] = wr_data_i;
    end
    if (rd_idx_i < 2'h3) begin
      rd_d = mem_d[rd_idx_i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    mem_q <= mem_d;
    rd_q <= rd_d;
  end

  assign rd_data_o = rd_q;

  genvar g;
  generate
    for (g = 0; g < `NUM_PINS; g++) begin : g_setup
      assign setup_o[g] = aux_pin_pkg::pin_setup_t'(mem_q[g]);
    end
  endgenerate

endmodule : aux_pin_reg_store

// ### design/aux_pin_bank.sv
// aux pin configuration bank: three pin setups, level registers, emphasis override
// assumes a management bus engine presents byte-wide register strobes, all synchronous to sys_clk_i
`timescale 1ns/10ps
`include "aux_pin_regs.svh"
module aux_pin_bank (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic soft_reset_o,
  input wire aux_pin_pkg::status_t status_i,
  input wire logic [2:0] pin_in_i,
  output logic [2:0] pin_out_o,
  output logic [2:0] pin_oe_n_o,
  output aux_pin_pkg::pad_ctrl_t [2:0] pad_ctrl_o,
  input wire logic [1:0] emph_pins_i,
  output aux_pin_pkg::emph_level_t emph_level_o
);

  logic clear;
  logic soft_reset_q;
  logic soft_reset_d;
  logic [2:0] levels_out_q;
  logic [2:0] levels_out_d;
  logic [2:0] levels_in_q;
  logic [2:0] levels_in_d;
  aux_pin_pkg::emphasis_t emph_q;
  aux_pin_pkg::emphasis_t emph_d;
  logic [2:0] pin_out_q;
  logic [2:0] pin_out_d;
  logic [2:0] oe_n_q;
  logic [2:0] oe_n_d;
  aux_pin_pkg::pad_ctrl_t [2:0] pad_q;
  aux_pin_pkg::pad_ctrl_t [2:0] pad_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [1:0] emph_lvl_d;
  logic [1:0] emph_lvl_q;
  logic [7:0] store_rdata;
  logic store_hit_q;
  logic store_hit_d;
  logic store_wr;
  logic [1:0] store_idx;
  aux_pin_pkg::pin_setup_t [2:0] setup;
  logic [2:0] src;

  // software reset pulse lasts one cycle and, like hardware reset, clears the setup store, software levels and emphasis register
  assign clear = !rst_n_i || soft_reset_q;

  assign store_wr = reg_wr_i && !clear && (reg_addr_i >= `ADDR_PIN0_SETUP) && (reg_addr_i <= `ADDR_PIN2_SETUP);
  assign store_idx = 2'(reg_addr_i - `ADDR_PIN0_SETUP);

  // selector, pull, buffer fields all return to defaults here
  aux_pin_reg_store u_store (
    .sys_clk_i(sys_clk_i),
    .clear_i(clear),
    .wr_en_i(store_wr),
    .wr_idx_i(store_idx),
    .wr_data_i(reg_wdata_i),
    .rd_idx_i(store_idx),
    .rd_data_o(store_rdata),
    .setup_o(setup)
  );

  always_comb begin
    soft_reset_d = 1'b0;
    levels_out_d = levels_out_q;
    emph_d = emph_q;
    if (clear) begin
      levels_out_d = `LEVELS_OUT_RESET_VAL;
      emph_d = aux_pin_pkg::emphasis_t'(`EMPHASIS_RESET_VAL);
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADDR_RESET: soft_reset_d = reg_wdata_i[`SOFT_RESET_BIT];
        `ADDR_LEVELS_OUT: levels_out_d = reg_wdata_i[2:0];
        `ADDR_EMPHASIS: emph_d = aux_pin_pkg::emphasis_t'(reg_wdata_i[2:0]);
        default: ;
      endcase
    end
  end

  // pin source mux; reserved codes fall to low
  always_comb begin
    src[0] = 1'b0;
    case (setup[0].source_select)
      `P0_SEL_SOFT: src[0] = levels_out_q[0];
      `P0_SEL_LINK_LOSS: src[0] = status_i.link_loss;
      `P0_SEL_CLK_LOS: src[0] = status_i.clk_los;
      `P0_SEL_CLK_DET: src[0] = status_i.clk_detect;
      default: src[0] = 1'b0;
    endcase
    src[1] = 1'b0;
    if (setup[1].source_select >= `P1_SEL_LANE_BASE && setup[1].source_select <= `P1_SEL_LANE_LAST) begin
      src[1] = status_i.lane_los[3'(setup[1].source_select - `P1_SEL_LANE_BASE)];
    end else begin
      case (setup[1].source_select)
        `P1_SEL_POR: src[1] = status_i.por;
        `P1_SEL_SOFT: src[1] = levels_out_q[1];
        `P1_SEL_PLL_LOCK: src[1] = status_i.pll_lock;
        default: src[1] = 1'b0;
      endcase
    end
    case (setup[2].source_select)
      `P2_SEL_SOFT: src[2] = levels_out_q[2];
      `P2_SEL_AON_CLK: src[2] = status_i.aon_clk;
      `P2_SEL_SER_CLK: src[2] = status_i.ser_clk;
      `P2_SEL_DIG_CLK: src[2] = status_i.dig_clk;
      default: src[2] = 1'b0;
    endcase
  end

  // clock sources pass through a flop, so they reach the pin at most half the sys rate
  always_comb begin
    for (int i = 0; i < `NUM_PINS; i++) begin
      pin_out_d[i] = src[i];
      oe_n_d[i] = !setup[i].output_enable;
      pad_d[i].in_buf_en = setup[i].input_enable;
      pad_d[i].pull_down_en = (setup[i].pull_control == `PULL_DOWN);
      pad_d[i].pull_up_en = (setup[i].pull_control == `PULL_UP);
      // a disabled input buffer reads low
      levels_in_d[i] = pin_in_i[i] && setup[i].input_enable;
    end
  end

  always_comb begin
    emph_lvl_d = emph_q.override_en ? emph_q.level : emph_pins_i;
  end

  always_comb begin
    store_hit_d = 1'b0;
    rdata_d = rdata_q;
    if (reg_rd_i) begin
      rdata_d = 8'h00;
      case (reg_addr_i)
        `ADDR_PIN0_SETUP, `ADDR_PIN1_SETUP, `ADDR_PIN2_SETUP: store_hit_d = 1'b1;
        `ADDR_LEVELS_IN: rdata_d = {5'h00, levels_in_q};
        `ADDR_LEVELS_OUT: rdata_d = {5'h00, levels_out_q};
        `ADDR_EMPHASIS: rdata_d = {5'h00, emph_q};
        default: rdata_d = 8'h00;
      endcase
    end else if (store_hit_q) begin
      // store read register follows the address, so keep its byte until the next read
      rdata_d = store_rdata;
    end
  end

  // control group: soft reset pulse, software levels, emphasis register
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      soft_reset_q <= 1'b0;
      levels_out_q <= `LEVELS_OUT_RESET_VAL;
      emph_q <= aux_pin_pkg::emphasis_t'(`EMPHASIS_RESET_VAL);
    end else begin
      soft_reset_q <= soft_reset_d;
      levels_out_q <= levels_out_d;
      emph_q <= emph_d;
    end
  end

  // pin group: drivers stay released during reset so nothing fights the board
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      levels_in_q <= `PIN_RESET_VAL;
      pin_out_q <= `PIN_RESET_VAL;
      oe_n_q <= `OE_N_RESET_VAL;
      pad_q <= '0;
    end else begin
      levels_in_q <= levels_in_d;
      pin_out_q <= pin_out_d;
      oe_n_q <= oe_n_d;
      pad_q <= pad_d;
    end
  end

  // emphasis output group
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      emph_lvl_q <= `EMPH_LEVEL_RESET_VAL;
    end else begin
      emph_lvl_q <= emph_lvl_d;
    end
  end

  // read group
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= `RDATA_RESET_VAL;
      store_hit_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      store_hit_q <= store_hit_d;
    end
  end

  assign reg_rdata_o = store_hit_q ? store_rdata : rdata_q;
  assign soft_reset_o = soft_reset_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_n_o = oe_n_q;
  assign pad_ctrl_o = pad_q;
  assign emph_level_o = aux_pin_pkg::emph_level_t'(emph_lvl_q);

endmodule : aux_pin_bank

// ### dv/aux_pin_bank_props.sv
// port assertions for the aux pin bank
// assumes bind onto aux_pin_bank; single clock domain
`timescale 1ns/10ps
module aux_pin_bank_props (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic soft_reset_o,
  input wire aux_pin_pkg::status_t status_i,
  input wire logic [2:0] pin_out_o,
  input wire logic [2:0] pin_oe_n_o,
  input wire aux_pin_pkg::pad_ctrl_t [2:0] pad_ctrl_o,
  input wire logic [1:0] emph_pins_i,
  input wire aux_pin_pkg::emph_level_t emph_level_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // writes during the soft reset cycle are dropped, so exclude them
  sequence s_wr(a);
    reg_wr_i && !soft_reset_o && reg_addr_i == a ##1 !reg_wr_i;
  endsequence
  sequence s_sel(a, c);
    reg_wr_i && !soft_reset_o && reg_addr_i == a && reg_wdata_i[7:4] == c ##1 !reg_wr_i ##1 !reg_wr_i;
  endsequence
  property p_reset_dflt;
    !$past(rst_n_i) |=> pin_oe_n_o == 3'h0 && pin_out_o[1] == $past(status_i.por) && !pin_out_o[0];
  endproperty
  a_reset_dflt: assert property (p_reset_dflt) else $error("reset defaults wrong");
  property p_sel0;
    s_sel(8'h02, 4'h1) |=> pin_out_o[0] == $past(status_i.link_loss);
  endproperty
  a_sel0: assert property (p_sel0) else $error("pin zero not on link loss");
  property p_sel1;
    s_sel(8'h03, 4'h3) |=> pin_out_o[1] == $past(status_i.lane_los[0]);
  endproperty
  a_sel1: assert property (p_sel1) else $error("pin one not on lane zero");
  property p_sel2;
    s_sel(8'h04, 4'h1) |=> pin_out_o[2] == $past(status_i.aon_clk);
  endproperty
  a_sel2: assert property (p_sel2) else $error("pin two not on always-on clock");
  property p_rsvd;
    s_sel(8'h02, 4'h2) |=> !pin_out_o[0];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code not low");
  property p_pad;
    s_wr(8'h02) |=> pin_oe_n_o[0] == !$past(reg_wdata_i[0], 2) && pad_ctrl_o[0] ==
      {$past(reg_wdata_i[3:2], 2) == 2'h2, $past(reg_wdata_i[3:2], 2) == 2'h1, $past(reg_wdata_i[1], 2)};
  endproperty
  a_pad: assert property (p_pad) else $error("pad control wrong");
  property p_emph;
    s_wr(8'h20) |=> emph_level_o == ($past(reg_wdata_i[2], 2) ? $past(reg_wdata_i[1:0], 2) : $past(emph_pins_i));
  endproperty
  a_emph: assert property (p_emph) else $error("emphasis level wrong");
  property p_in_rsvd;
    reg_rd_i && reg_addr_i == 8'h05 |=> reg_rdata_o[7:3] == 5'h0;
  endproperty
  a_in_rsvd: assert property (p_in_rsvd) else $error("input reserved bits set");
  property p_soft;
    reg_wr_i && !soft_reset_o && reg_addr_i == 8'h01 && reg_wdata_i[0] |=> soft_reset_o ##1 !soft_reset_o;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
  property p_soft_dflt;
    soft_reset_o |-> ##2 (pin_oe_n_o == 3'h0 && pad_ctrl_o == 9'h092);
  endproperty
  a_soft_dflt: assert property (p_soft_dflt) else $error("soft reset defaults wrong");
endmodule : aux_pin_bank_props
bind aux_pin_bank aux_pin_bank_props u_props (.*);

// ### dv/aux_pin_pads.sv
// pad wire model for the three aux pins
// assumes nothing else loads the pins; a floating pin toggles each clock
`timescale 1ns/10ps
module aux_pin_pads (
  input wire logic sys_clk_i,
  input wire logic [2:0] pin_out_i,
  input wire logic [2:0] pin_oe_n_i,
  input wire aux_pin_pkg::pad_ctrl_t [2:0] pad_ctrl_i,
  output logic [2:0] pin_level_o
);
  logic float_q = 1'b0;
  // toggling so a floating pin never reads as a steady value
  always @(posedge sys_clk_i) float_q <= !float_q;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!pin_oe_n_i[i]) pin_level_o[i] = pin_out_i[i];
      else if (pad_ctrl_i[i].pull_up_en) pin_level_o[i] = 1'b1;
      else if (pad_ctrl_i[i].pull_down_en) pin_level_o[i] = 1'b0;
      else pin_level_o[i] = float_q;
    end
  end
endmodule : aux_pin_pads

// ### dv/aux_pin_bank_tb.sv
// self-checking bench for the aux pin bank
// assumes the pad model closes the pin loop
`timescale 1ns/10ps
module aux_pin_bank_tb;
  logic sys_clk_i = 1'b0;
  logic rst_n_i, reg_wr_i, reg_rd_i, soft_reset_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  aux_pin_pkg::status_t status_i;
  logic [2:0] pin_in_i, pin_out_o, pin_oe_n_o;
  aux_pin_pkg::pad_ctrl_t [2:0] pad_ctrl_o;
  logic [1:0] emph_pins_i;
  aux_pin_pkg::emph_level_t emph_level_o;
  int errors = 0;
  int compares = 0;
  logic [7:0] adr [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h20, 8'h07};
  logic [7:0] dflt [7] = '{8'h05, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
  initial forever #4 sys_clk_i = !sys_clk_i;
  aux_pin_bank DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .soft_reset_o(soft_reset_o),
    .status_i(status_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .pad_ctrl_o(pad_ctrl_o), .emph_pins_i(emph_pins_i), .emph_level_o(emph_level_o));
  aux_pin_pads pads (.sys_clk_i(sys_clk_i), .pin_out_i(pin_out_o), .pin_oe_n_i(pin_oe_n_o),
    .pad_ctrl_i(pad_ctrl_o), .pin_level_o(pin_in_i));
  task finish_test;
    if (errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task cmp(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    cmp(reg_rdata_o, exp);
  endtask : rd
  // outputs trail a register change by one rising edge
  task tick;
    repeat (2) @(negedge sys_clk_i);
  endtask : tick
  task dflts;
    for (int i = 0; i < 7; i++) rd(adr[i], dflt[i]);
  endtask : dflts
  task sel(input logic [7:0] a, input logic [3:0] c, input int n, input int p);
    @(posedge sys_clk_i);
    status_i <= 13'h1 << n;
    wr(a, {c, 4'h1});
    tick;
    cmp(pin_out_o[p], 9'h1);
    @(posedge sys_clk_i);
    status_i <= ~(13'h1 << n);
    tick;
    cmp(pin_out_o[p], 9'h0);
  endtask : sel
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    finish_test;
  end
  initial begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    status_i = '0;
    emph_pins_i = 2'h2;
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    status_i <= 13'h100;
    tick;
    @(negedge sys_clk_i);
    cmp(pin_out_o, 9'h2);
    cmp(pin_oe_n_o, 9'h0);
    cmp(pad_ctrl_o, 9'h092);
    dflts;
    wr(8'h02, 8'h03);
    wr(8'h03, 8'h13);
    wr(8'h04, 8'h03);
    wr(8'h06, 8'hFC);
    tick;
    cmp(pin_out_o, 9'h4);
    rd(8'h06, 8'h04);
    rd(8'h05, 8'h04);
    wr(8'h02, 8'h0A);
    wr(8'h05, 8'hFF);
    tick;
    cmp(pin_oe_n_o, 9'h1);
    cmp(pad_ctrl_o[0], 9'h5);
    rd(8'h05, 8'h05);
    sel(8'h02, 4'h1, 12, 0);
    sel(8'h02, 4'h3, 11, 0);
    sel(8'h02, 4'h4, 10, 0);
    sel(8'h03, 4'h2, 9, 1);
    for (int c = 3; c < 8; c++) sel(8'h03, 4'(c), c, 1);
    sel(8'h04, 4'h1, 2, 2);
    sel(8'h04, 4'h2, 1, 2);
    sel(8'h04, 4'h4, 0, 2);
    @(posedge sys_clk_i);
    status_i <= '1;
    wr(8'h03, 8'h81);
    wr(8'h04, 8'h31);
    wr(8'h02, 8'h21);
    tick;
    cmp(pin_out_o, 9'h0);
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 8'(4 + i));
      tick;
      cmp(emph_level_o, 9'(i));
    end
    wr(8'h20, 8'h01);
    tick;
    cmp(emph_level_o, 9'h2);
    rd(8'h20, 8'h01);
    wr(8'h01, 8'h01);
    @(negedge sys_clk_i);
    cmp(soft_reset_o, 9'h1);
    tick;
    cmp(soft_reset_o, 9'h0);
    cmp(pad_ctrl_o, 9'h092);
    dflts;
    finish_test;
  end
endmodule : aux_pin_bank_tb
